// *** hw/cdsc_map.vh ***
// Overview of operation
// RL1 - capture serial bit on rising clock while selected
// RL2 - frame: command, address, then 16-bit data
// RL3 - 12-bit variant ignores four trailing data bits
// RL4 - select rise executes last 24 bits
// RL5 - 32-bit frames prefix eight ignored bits
// RL6 - fault register shifts out serially each frame
// RL7 - code write to one or all
// RL8 - span write to one or all
// RL9 - power up and update one or all
// RL10 - write code then update one or all
// RL11 - power down one channel or whole chip
// RL12 - addresses above four are ignored
// RL13 - five holding registers per channel
// RL14 - writes never touch output registers
// RL15 - register B only used by toggle
// RL16 - update copies input into output registers
// RL17 - update clears channel power-down
// RL18 - update copies code and span together
// RL19 - update from command, load strobe, toggle
// RL20 - power-up leaves all outputs off
// RL21 - code is unsigned straight binary
// RL22 - clear zeroes codes, spans, control registers
// RL23 - fault low on fault, released at select rise
// RL24 - unassigned span codes mean off mode
// RL25 - decode remaining codes; no-operation changes nothing
`ifndef CDSC_MAP_VH
`define CDSC_MAP_VH
`define CDSC_CMD_WR_X 4'h0
`define CDSC_CMD_UPD_X 4'h1
`define CDSC_CMD_WR_X_UPD_ALL 4'h2
`define CDSC_CMD_WR_UPD_X 4'h3
`define CDSC_CMD_PD_X 4'h4
`define CDSC_CMD_PD_CHIP 4'h5
`define CDSC_CMD_SPAN_X 4'h6
`define CDSC_CMD_CONFIG 4'h7
`define CDSC_CMD_WR_ALL 4'h8
`define CDSC_CMD_UPD_ALL 4'h9
`define CDSC_CMD_WR_UPD_ALL 4'ha
`define CDSC_CMD_MUX 4'hb
`define CDSC_CMD_TOG_SEL 4'hc
`define CDSC_CMD_TOG_GLOBAL 4'hd
`define CDSC_CMD_SPAN_ALL 4'he
`define CDSC_CMD_NOP 4'hf
`define CDSC_CMD_MSB 23
`define CDSC_CMD_LSB 20
`define CDSC_ADDR_MSB 19
`define CDSC_ADDR_LSB 16
`define CDSC_DATA_MSB 15
`define CDSC_DATA_LSB 0
`define CDSC_SPAN_MSB 3
`define CDSC_SPAN_LSB 0
`define CDSC_MUX_MSB 4
`define CDSC_TSEL_MSB 4
`define CDSC_TOG_BIT 0
`define CDSC_NUM_CH 5
`define CDSC_SPAN_OFF 4'h0
`define CDSC_SPAN_MAX_LOW 4'h7
`define CDSC_SPAN_SWITCH 4'h8
`define CDSC_SPAN_TOP 4'hf
`define CDSC_RESET_CODE 16'h0000
`define CDSC_RESET_SPAN 4'h0
`endif

// *** hw/cdsc_sync.v ***
`timescale 1ns/10ps
module cdsc_sync
#(
    parameter W = 1
)
(
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // level in and out
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule // cdsc_sync

// *** hw/cdsc_core.v ***
`timescale 1ns/10ps
`include "cdsc_map.vh"
module cdsc_core
#(
    parameter NCH = `CDSC_NUM_CH,
    parameter DW = 16,
    parameter RES = 16,
    parameter FW = 8
)
(
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // serial link pins
    input wire serial_clk,
    input wire serial_in,
    input wire select_and_load_n,
    output reg serial_out_q,
    // control pins
    input wire async_load_strobe_n,
    input wire async_clear_n,
    input wire toggle_pin,
    // fault sources and open-drain fault pin
    input wire [FW-1:0] fault_flags,
    output reg fault_n_out_q,
    output reg fault_n_oe_q,
    // channel state
    output reg [NCH*DW-1:0] out_code_q,
    output reg [NCH*4-1:0] out_span_q,
    output reg [NCH-1:0] out_mode_off_q,
    output reg [NCH-1:0] out_switch_q,
    output reg [NCH-1:0] out_powered_q,
    output reg [4:0] mux_select_q,
    output reg [3:0] config_q
);
    reg rs1_q;
    reg rs2_q;
    wire rst_i_n;
    wire sck_s;
    wire sdi_s;
    wire cs_s;
    wire async_load_strobe_n_s;
    wire clr_s;
    wire tog_s;
    wire [FW-1:0] flt_s;
    wire cs_act;
    wire async_load_strobe_n_act;
    wire clr_act;
    reg sck_d1_q;
    reg cs_d1_q;
    reg async_load_strobe_n_d1_q;
    reg tog_d1_q;
    reg [31:0] shift_q;
    reg [FW-1:0] fault_sh_q;
    reg [FW-1:0] fault_reg_q;
    reg [DW-1:0] in_a_q [0:NCH-1];
    reg [DW-1:0] in_b_q [0:NCH-1];
    reg [3:0] in_span_q [0:NCH-1];
    reg [DW-1:0] dac_code_q [0:NCH-1];
    reg [3:0] dac_span_q [0:NCH-1];
    reg [NCH-1:0] pd_q;
    reg [NCH-1:0] tsel_q;
    reg gtog_q;
    reg tog_upd_q;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;
    wire async_load_strobe_n_fall;
    wire [3:0] cmd;
    wire [3:0] addr;
    wire [DW-1:0] data;
    wire addr_ok;
    wire [DW-1:0] data_m;
    integer k;
    integer j;
    // reset release
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    assign rst_i_n = rs2_q;
    cdsc_sync #(.W(FW + 6)) u_sync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_i_n),
        .din({fault_flags, toggle_pin, ~async_clear_n, ~async_load_strobe_n,
              ~select_and_load_n, serial_in, serial_clk}),
        .dout({flt_s, tog_s, clr_act, async_load_strobe_n_act, cs_act, sdi_s, sck_s})
    );
    // active-low pins cross inverted so reset equals idle
    assign clr_s = ~clr_act;
    assign async_load_strobe_n_s = ~async_load_strobe_n_act;
    assign cs_s = ~cs_act;
    assign sck_rise = sck_s & ~sck_d1_q;
    assign sck_fall = ~sck_s & sck_d1_q;
    assign cs_rise = cs_s & ~cs_d1_q;
    assign async_load_strobe_n_fall = ~async_load_strobe_n_s & async_load_strobe_n_d1_q;
    // last 24 bits decide; any 8-bit prefix falls off the top
    assign cmd = shift_q[`CDSC_CMD_MSB:`CDSC_CMD_LSB]; // [RL2] [RL4] [RL5]
    assign addr = shift_q[`CDSC_ADDR_MSB:`CDSC_ADDR_LSB];
    assign data = shift_q[`CDSC_DATA_MSB:`CDSC_DATA_LSB];
    assign addr_ok = (addr < NCH); // [RL12]
    // low-resolution build drops trailing bits
    assign data_m = (RES < DW) ? ((data >> (DW - RES)) << (DW - RES)) : data; // [RL3] [RL21]
    // edge detectors and serial shift register
    always @(posedge clk_sys or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            sck_d1_q <= 1'b0;
            cs_d1_q <= 1'b1;
            async_load_strobe_n_d1_q <= 1'b1;
            tog_d1_q <= 1'b0;
            shift_q <= 32'h00000000;
        end
        else
        begin
            sck_d1_q <= sck_s;
            cs_d1_q <= cs_s;
            async_load_strobe_n_d1_q <= async_load_strobe_n_s;
            tog_d1_q <= tog_s;
            if (!cs_s && sck_rise)
            begin
                shift_q <= {shift_q[30:0], sdi_s}; // [RL1]
            end
        end
    end
    // fault shifter: load at frame start, shift on falling clock
    always @(posedge clk_sys or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            fault_sh_q <= {FW{1'b0}};
            serial_out_q <= 1'b0;
        end
        else
        begin
            if (cs_d1_q && !cs_s)
            begin
                fault_sh_q <= fault_reg_q;
                serial_out_q <= fault_reg_q[FW-1]; // [RL6]
            end
            else if (!cs_s && sck_fall)
            begin
                fault_sh_q <= {fault_sh_q[FW-2:0], 1'b0};
                serial_out_q <= fault_sh_q[FW-2]; // [RL6]
            end
        end
    end
    // sticky fault flags and open-drain pin
    always @(posedge clk_sys or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            fault_reg_q <= {FW{1'b0}};
            fault_n_out_q <= 1'b0;
            fault_n_oe_q <= 1'b1;
        end
        else
        begin
            // new faults win over release at select rise
            if (cs_rise)
            begin
                fault_reg_q <= flt_s; // [RL23]
            end
            else
            begin
                fault_reg_q <= fault_reg_q | flt_s;
            end
            fault_n_oe_q <= ~((|flt_s) | ((|fault_reg_q) & ~cs_rise)); // [RL23]
        end
    end
    // command execution and channel registers
    always @(posedge clk_sys or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            for (k = 0; k < NCH; k = k + 1)
            begin
                in_a_q[k] <= `CDSC_RESET_CODE;
                in_b_q[k] <= `CDSC_RESET_CODE;
                in_span_q[k] <= `CDSC_RESET_SPAN; // [RL20]
                dac_code_q[k] <= `CDSC_RESET_CODE;
                dac_span_q[k] <= `CDSC_RESET_SPAN; // [RL20]
            end
            pd_q <= {NCH{1'b1}}; // [RL20]
            tsel_q <= {NCH{1'b0}};
            gtog_q <= 1'b0;
            tog_upd_q <= 1'b0;
            mux_select_q <= 5'h00;
            config_q <= 4'h0;
        end
        else if (!clr_s)
        begin
            for (k = 0; k < NCH; k = k + 1)
            begin
                in_a_q[k] <= `CDSC_RESET_CODE; // [RL22]
                in_b_q[k] <= `CDSC_RESET_CODE;
                in_span_q[k] <= `CDSC_RESET_SPAN;
                dac_code_q[k] <= `CDSC_RESET_CODE;
                dac_span_q[k] <= `CDSC_RESET_SPAN;
            end
            pd_q <= {NCH{1'b1}}; // [RL22]
            tsel_q <= {NCH{1'b0}}; // [RL22]
            gtog_q <= 1'b0;
            tog_upd_q <= 1'b0;
            mux_select_q <= 5'h00;
            config_q <= 4'h0;
        end
        else
        begin
            tog_upd_q <= tog_s ^ tog_d1_q;
            for (k = 0; k < NCH; k = k + 1)
            begin
                if (cs_rise && addr_ok)
                begin
                    // code into A only; outputs untouched by writes
                    if (((cmd == `CDSC_CMD_WR_X || cmd == `CDSC_CMD_WR_UPD_X ||
                          cmd == `CDSC_CMD_WR_X_UPD_ALL) && addr == k) ||
                        cmd == `CDSC_CMD_WR_ALL || cmd == `CDSC_CMD_WR_UPD_ALL)
                    begin
                        in_a_q[k] <= data_m; // [RL7] [RL14] [RL15]
                    end
                    if ((cmd == `CDSC_CMD_SPAN_X && addr == k) ||
                        cmd == `CDSC_CMD_SPAN_ALL)
                    begin
                        in_span_q[k] <= data[`CDSC_SPAN_MSB:`CDSC_SPAN_LSB]; // [RL8]
                    end
                    if (((cmd == `CDSC_CMD_UPD_X || cmd == `CDSC_CMD_WR_UPD_X) &&
                         addr == k) || cmd == `CDSC_CMD_UPD_ALL ||
                        cmd == `CDSC_CMD_WR_X_UPD_ALL || cmd == `CDSC_CMD_WR_UPD_ALL)
                    begin
                        // written value forwarded so update sees it
                        dac_code_q[k] <= (((cmd == `CDSC_CMD_WR_UPD_X ||
                            cmd == `CDSC_CMD_WR_X_UPD_ALL) && addr == k) ||
                            cmd == `CDSC_CMD_WR_UPD_ALL) ? data_m : in_a_q[k]; // [RL9] [RL10]
                        dac_span_q[k] <= in_span_q[k]; // [RL16] [RL18]
                        pd_q[k] <= 1'b0; // [RL17]
                    end
                    if (cmd == `CDSC_CMD_PD_X && addr == k)
                    begin
                        pd_q[k] <= 1'b1; // [RL11]
                    end
                    if (cmd == `CDSC_CMD_PD_CHIP)
                    begin
                        pd_q[k] <= 1'b1; // [RL11]
                    end
                end
                else if (async_load_strobe_n_fall || (tog_upd_q && tsel_q[k]))
                begin
                    // toggle selects B on channels picked by select register
                    dac_code_q[k] <= (tsel_q[k] && (gtog_q ^ tog_s)) ?
                                     in_b_q[k] : in_a_q[k]; // [RL19] [RL15]
                    dac_span_q[k] <= in_span_q[k]; // [RL18]
                    pd_q[k] <= 1'b0; // [RL17]
                end
            end
            if (cs_rise && addr_ok)
            begin
                case (cmd)
                    `CDSC_CMD_MUX: mux_select_q <= data[`CDSC_MUX_MSB:0]; // [RL25]
                    `CDSC_CMD_TOG_SEL: tsel_q <= data[NCH-1:0]; // [RL25]
                    `CDSC_CMD_TOG_GLOBAL: gtog_q <= data[`CDSC_TOG_BIT]; // [RL25]
                    `CDSC_CMD_CONFIG: config_q <= data[3:0]; // [RL25]
                    default: ; // no-operation leaves all state [RL25]
                endcase
            end
        end
    end
    // output registers drive the pins
    always @(posedge clk_sys or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            out_code_q <= {NCH*DW{1'b0}};
            out_span_q <= {NCH*4{1'b0}};
            out_mode_off_q <= {NCH{1'b1}};
            out_switch_q <= {NCH{1'b0}};
            out_powered_q <= {NCH{1'b0}};
        end
        else
        begin
            for (j = 0; j < NCH; j = j + 1)
            begin
                out_code_q[j*DW +: DW] <= dac_code_q[j]; // [RL16] [RL13]
                out_span_q[j*4 +: 4] <= dac_span_q[j];
                out_switch_q[j] <= (dac_span_q[j] == `CDSC_SPAN_SWITCH);
                out_mode_off_q[j] <= !((dac_span_q[j] != `CDSC_SPAN_OFF &&
                    dac_span_q[j] <= `CDSC_SPAN_MAX_LOW) ||
                    dac_span_q[j] == `CDSC_SPAN_TOP ||
                    dac_span_q[j] == `CDSC_SPAN_SWITCH); // [RL24]
                out_powered_q[j] <= ~pd_q[j];
            end
        end
    end
endmodule // cdsc_core

// *** dv/cdsc_core_checker.sv ***
`timescale 1ns/10ps
module cdsc_core_checker
#(
    parameter NCH = 5,
    parameter DW = 16,
    parameter FW = 8
)
(
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // pins in
    input wire select_and_load_n,
    input wire async_load_strobe_n,
    input wire async_clear_n,
    input wire toggle_pin,
    input wire [FW-1:0] fault_flags,
    // state out
    input wire fault_n_out_q,
    input wire fault_n_oe_q,
    input wire [NCH*DW-1:0] out_code_q,
    input wire [NCH*4-1:0] out_span_q,
    input wire [NCH-1:0] out_mode_off_q,
    input wire [NCH-1:0] out_powered_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [NCH-1:0] off_exp;
    logic [3:0] idle_q;
    logic sel_q, ld_q, tg_q;
    always_comb
    begin
        for (int k = 0; k < NCH; k++)
            off_exp[k] = !(out_span_q[4*k+:4] inside {[4'h1:4'h8], 4'hf});
    end
    // cycles since the last event that may move the outputs
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idle_q <= 4'h0;
            sel_q <= 1'b1;
            ld_q <= 1'b1;
            tg_q <= 1'b0;
        end
        else
        begin
            sel_q <= select_and_load_n;
            ld_q <= async_load_strobe_n;
            tg_q <= toggle_pin;
            if ((select_and_load_n && !sel_q) || ld_q != async_load_strobe_n
                || tg_q != toggle_pin || !async_clear_n)
                idle_q <= 4'h0;
            else if (idle_q != 4'hf)
                idle_q <= idle_q + 4'h1;
        end
    end
    a_mode_off_span: assert property (out_mode_off_q == off_exp)
        else $error("mode flags disagree with span");
    a_reset_all_off: assert property ($rose(rst_n) |-> out_powered_q == '0 && &out_mode_off_q)
        else $error("outputs not off after reset");
    a_strobe_powers_up: assert property ($fell(async_load_strobe_n) && async_clear_n
        |-> ##[2:8] &out_powered_q)
        else $error("strobe did not update all channels");
    a_clear_zeroes: assert property (!async_clear_n [*6]
        |-> out_code_q == '0 && out_span_q == '0 && out_powered_q == '0)
        else $error("clear did not zero channel state");
    a_outputs_quiet: assert property (idle_q == 4'hf
        |-> $stable(out_code_q) && $stable(out_span_q))
        else $error("outputs moved without an update");
    a_fault_pulls: assert property (fault_flags != '0 |-> ##[1:6] !fault_n_oe_q)
        else $error("fault not signalled");
    a_fault_release: assert property ((fault_flags == '0) [*4] ##1 $rose(select_and_load_n)
        ##1 (fault_flags == '0) [*6] |-> fault_n_oe_q)
        else $error("fault not released after select rise");
    a_fault_drives_low: assert property (fault_n_out_q == 1'b0)
        else $error("fault pin driven high");
endmodule // cdsc_core_checker

bind cdsc_core cdsc_core_checker #(.NCH(NCH), .DW(DW), .FW(FW)) u_cdsc_core_checker (
    .clk_sys, .rst_n, .select_and_load_n, .async_load_strobe_n, .async_clear_n,
    .toggle_pin, .fault_flags, .fault_n_out_q, .fault_n_oe_q, .out_code_q,
    .out_span_q, .out_mode_off_q, .out_powered_q);

// *** dv/cdsc_host.sv ***
`timescale 1ns/10ps
module cdsc_host
(
    // pacing clock
    input wire clk_sys,
    // serial link
    output logic serial_clk,
    output logic serial_in,
    output logic select_and_load_n
);
    initial
    begin
        serial_clk = 1'b0;
        serial_in = 1'b0;
        select_and_load_n = 1'b1;
    end
    // one frame msb first; link clock stands low between frames
    task automatic send(input logic [31:0] word, input int nbits);
        @(posedge clk_sys) #1;
        select_and_load_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            serial_in = word[i];
            repeat (4) @(posedge clk_sys) #1;
            serial_clk = 1'b1;
            repeat (4) @(posedge clk_sys) #1;
            serial_clk = 1'b0;
        end
        repeat (4) @(posedge clk_sys) #1;
        select_and_load_n = 1'b1;
        serial_in = ~serial_in;
        repeat (4) @(posedge clk_sys) #1;
    endtask
endmodule // cdsc_host

// *** dv/current_dac_serial_command_core_tb.sv ***
`timescale 1ns/10ps
module current_dac_serial_command_core_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic async_load_strobe_n = 1'b1;
    logic async_clear_n = 1'b1;
    logic toggle_pin = 1'b0;
    logic [7:0] fault_flags = 8'h00;
    wire serial_clk, serial_in, select_and_load_n, serial_out_q, fault_n_out_q, fault_n_oe_q;
    wire [79:0] out_code_q;
    wire [19:0] out_span_q;
    wire [4:0] out_mode_off_q, out_switch_q, out_powered_q, mux_select_q;
    wire [3:0] config_q;
    int num_errors = 0;
    int total_checks = 0;
    always #20 clk_sys = ~clk_sys;
    cdsc_host u_cdsc_host (.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_in(serial_in),
        .select_and_load_n(select_and_load_n));
    cdsc_core u_cdsc_core (.clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .select_and_load_n(select_and_load_n),
        .serial_out_q(serial_out_q), .async_load_strobe_n(async_load_strobe_n),
        .async_clear_n(async_clear_n), .toggle_pin(toggle_pin), .fault_flags(fault_flags),
        .fault_n_out_q(fault_n_out_q), .fault_n_oe_q(fault_n_oe_q), .out_code_q(out_code_q),
        .out_span_q(out_span_q), .out_mode_off_q(out_mode_off_q), .out_switch_q(out_switch_q),
        .out_powered_q(out_powered_q), .mux_select_q(mux_select_q), .config_q(config_q));
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys) #1;
    endtask
    task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        u_cdsc_host.send({8'h00, c, a, d}, 24);
        tick(8);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_single;
        frame(4'h0, 4'h2, 16'h8001);
        frame(4'h6, 4'h2, 16'h0007);
        check(out_code_q, '0);
        check(out_span_q, '0);
        frame(4'h1, 4'h2, 16'h0000);
        check(out_code_q[47:32], 16'h8001);
        check(out_powered_q, 5'h04);
        check(out_mode_off_q, 5'h1b);
        frame(4'h3, 4'h2, 16'hfffe);
        check(out_code_q[47:32], 16'hfffe);
        check(out_span_q[11:8], 4'h7);
    endtask
    task automatic t_all;
        frame(4'h8, 4'h0, 16'h1234);
        frame(4'he, 4'h0, 16'h000f);
        check(out_span_q[11:8], 4'h7);
        async_load_strobe_n = 1'b0;
        tick(3);
        async_load_strobe_n = 1'b1;
        tick(8);
        check(out_code_q, {5{16'h1234}});
        check(out_span_q, {5{4'hf}});
        check(out_powered_q, 5'h1f);
        frame(4'ha, 4'h0, 16'hbeef);
        check(out_code_q, {5{16'hbeef}});
        frame(4'h2, 4'h4, 16'h0042);
        check(out_code_q, {16'h0042, {4{16'hbeef}}});
    endtask
    task automatic t_refuse;
        frame(4'ha, 4'h5, 16'h0000);
        frame(4'h8, 4'hf, 16'h0000);
        frame(4'hf, 4'h0, 16'h0000);
        check(out_code_q, {16'h0042, {4{16'hbeef}}});
        u_cdsc_host.send({8'ha5, 4'h3, 4'h0, 16'h5555}, 32);
        tick(8);
        check(out_code_q[15:0], 16'h5555);
        frame(4'h6, 4'h1, 16'h0009);
        frame(4'h6, 4'h3, 16'h0008);
        frame(4'h1, 4'h1, 16'h0000);
        frame(4'h1, 4'h3, 16'h0000);
        check(out_mode_off_q, 5'h02);
        check(out_switch_q, 5'h08);
    endtask
    task automatic t_power;
        frame(4'h4, 4'h1, 16'h0000);
        frame(4'h4, 4'h7, 16'h0000);
        check(out_powered_q, 5'h1d);
        frame(4'h5, 4'h0, 16'h0000);
        check(out_powered_q, 5'h00);
        frame(4'h9, 4'h0, 16'h0000);
        check(out_powered_q, 5'h1f);
    endtask
    task automatic t_toggle;
        frame(4'hc, 4'h0, 16'h0001);
        toggle_pin = 1'b1;
        tick(8);
        check(out_code_q, {16'h0042, {3{16'hbeef}}, 16'h0000});
        toggle_pin = 1'b0;
        tick(8);
        check(out_code_q[15:0], 16'h5555);
    endtask
    task automatic t_clear_fault;
        logic [7:0] got;
        frame(4'h7, 4'h0, 16'h0005);
        frame(4'hb, 4'h0, 16'h000a);
        check({mux_select_q, config_q}, {5'h0a, 4'h5});
        fault_flags = 8'h10;
        tick(6);
        fault_flags = 8'h00;
        tick(6);
        check(fault_n_oe_q, 1'b0);
        fork
            frame(4'hf, 4'h0, 16'h0000);
            repeat (8) @(posedge serial_clk) got = {got[6:0], serial_out_q};
        join
        check(got, 8'h10);
        check(fault_n_oe_q, 1'b1);
        async_clear_n = 1'b0;
        tick(8);
        async_clear_n = 1'b1;
        tick(4);
        check({out_code_q, out_span_q, out_mode_off_q, out_powered_q},
            {100'h0, 5'h1f, 5'h00});
        check({mux_select_q, config_q}, '0);
    endtask
    initial
    begin
        tick(4);
        rst_n = 1'b1;
        tick(6);
        check({out_code_q, out_span_q, out_powered_q}, '0);
        check({out_mode_off_q, fault_n_oe_q}, 6'h3f);
        t_single;
        t_all;
        t_refuse;
        t_power;
        t_toggle;
        t_clear_fault;
        give_verdict;
    end
    initial
    begin
        #2000000;
        num_errors++;
        give_verdict;
    end
endmodule // current_dac_serial_command_core_tb
